// ### logic/cpr_readout.v
// Configuration memory read-out controller with APB register access.
//
// Contract
// R1 - Chip select high enters low-power standby.
// R2 - Standby clears counter, cascade high, outputs off.
// R3 - Partner keeps test pins high, clock static.
// R4 - Counter stops at terminal count, cascade low.
// R5 - Revision end stops counter, outputs off, cascade high.
// R6 - Revision mode resets load selected bank start.
// R7 - Without revisions resets return counter to zero.
// R8 - Busy honoured only parallel, no decompression.
// R9 - Reset line released after power-on delay.
// R10 - Core supply below threshold 10 ms resets.
// R11 - Partner waits for both supplies before configuring.
// R12 - Reset line low holds counter, outputs off.
// R13 - Device drives reset line low during power-up.
// R14 - Honoured busy freezes counter, data and clock.
// R15 - Config pulse low restarts counter, outputs stay.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`include "cpr_defines.vh"

module cpr_readout #(
	parameter integer ADDR_W = 8,
	parameter integer DATA_W = 8,
	parameter integer REL_CYC = `CPR_RESET_RELEASE_CYC,
	parameter integer RST_CYC = `CPR_TRST_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire chip_select_n,
	input wire oe_reset_in,
	output reg oe_reset_out,
	output reg oe_reset_oe,
	input wire config_pulse_n_in,
	output reg config_pulse_n_out,
	output reg config_pulse_n_oe,
	input wire busy,
	input wire data_clock,
	input wire supply_ok,
	input wire core_below_pd,
	output reg [DATA_W-1:0] data_out,
	output reg data_oe,
	output reg forwarded_clock_out,
	output reg forwarded_clock_oe,
	output reg cascade_enable_out_n
);
	localparam [ADDR_W-1:0] TERMINAL = {ADDR_W{1'b1}};
	localparam [31:0] START_RST = `CPR_START_RST;
	localparam [31:0] END_RST = `CPR_END_RST;

	reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	reg [31:0] ctrl;
	reg [ADDR_W-1:0] rev_start;
	reg [ADDR_W-1:0] rev_end;
	reg [ADDR_W-1:0] load_ptr;
	reg [ADDR_W-1:0] addr;
	reg clk_q;
	reg stopped;
	wire pwr_ready;

	// ****************************************************************
	// Power sequencing
	// ****************************************************************
	cpr_power_seq #(
		.REL_CYC(REL_CYC),
		.RST_CYC(RST_CYC)
	) u_pwr (
		.pclk(pclk),
		.presetn(presetn),
		.supply_ok(supply_ok),
		.below_pd(core_below_pd),
		.ready(pwr_ready)
	);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_reset_out <= 1'b0;
			oe_reset_oe <= 1'b1;
			config_pulse_n_out <= 1'b1;
			config_pulse_n_oe <= 1'b0;
		end else begin
			oe_reset_out <= 1'b0;
			oe_reset_oe <= ~pwr_ready; // R13
			config_pulse_n_out <= 1'b1;
			config_pulse_n_oe <= 1'b0;
		end
	end

	// ****************************************************************
	// Address counter and outputs
	// ****************************************************************
	wire rev_en = ctrl[`CPR_CTRL_REV_EN];
	wire [ADDR_W-1:0] reset_addr = rev_en ? rev_start : {ADDR_W{1'b0}}; // R6 R7
	wire busy_ok = ctrl[`CPR_CTRL_PARALLEL] & ~ctrl[`CPR_CTRL_DECOMP]; // R8
	wire in_reset = ~oe_reset_in | ~pwr_ready;
	wire read_edge = data_clock & ~clk_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr <= {ADDR_W{1'b0}};
			clk_q <= 1'b0;
			stopped <= 1'b0;
			data_out <= {DATA_W{1'b0}};
			data_oe <= 1'b0;
			forwarded_clock_out <= 1'b0;
			forwarded_clock_oe <= 1'b0;
			cascade_enable_out_n <= 1'b1;
		end else begin
			clk_q <= data_clock;
			if (chip_select_n || in_reset) begin // R1 R2 R12
				addr <= reset_addr;
				stopped <= 1'b0;
				data_oe <= 1'b0;
				forwarded_clock_oe <= 1'b0;
				cascade_enable_out_n <= 1'b1;
				data_out <= mem[reset_addr];
			end else if (!config_pulse_n_in) begin // R15
				addr <= reset_addr;
				stopped <= 1'b0;
				data_oe <= 1'b1;
				forwarded_clock_oe <= 1'b1;
				cascade_enable_out_n <= 1'b1;
				forwarded_clock_out <= data_clock;
				data_out <= mem[reset_addr];
			end else if (busy_ok && busy) begin // R14
				data_oe <= ~stopped;
				forwarded_clock_oe <= ~stopped;
			end else if (addr == TERMINAL) begin // R4
				stopped <= 1'b1;
				data_oe <= 1'b0;
				forwarded_clock_oe <= 1'b0;
				cascade_enable_out_n <= 1'b0;
			end else if (rev_en && addr == rev_end) begin // R5
				stopped <= 1'b1;
				data_oe <= 1'b0;
				forwarded_clock_oe <= 1'b0;
				cascade_enable_out_n <= 1'b1;
			end else begin
				data_oe <= 1'b1;
				forwarded_clock_oe <= 1'b1;
				cascade_enable_out_n <= 1'b1;
				forwarded_clock_out <= data_clock;
				if (read_edge) begin // R4
					addr <= addr + {{(ADDR_W-1){1'b0}}, 1'b1};
					data_out <= mem[addr + {{(ADDR_W-1){1'b0}}, 1'b1}];
				end else begin
					data_out <= mem[addr];
				end
			end
		end
	end

	// ****************************************************************
	// APB slave
	// ****************************************************************
	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `CPR_OFF_CTRL) || (a == `CPR_OFF_START) ||
				(a == `CPR_OFF_END) || (a == `CPR_OFF_LOAD_PTR) ||
				(a == `CPR_OFF_LOAD_DATA) || (a == `CPR_OFF_STATUS);
		end
	endfunction

	wire setup = psel & ~penable;
	wire wr = psel & penable & pwrite & pready;
	reg [31:0] rd_val;

	always @* begin
		rd_val = 32'h0000_0000;
		if (paddr == `CPR_OFF_CTRL) begin
			rd_val = ctrl;
		end else if (paddr == `CPR_OFF_START) begin
			rd_val[ADDR_W-1:0] = rev_start;
		end else if (paddr == `CPR_OFF_END) begin
			rd_val[ADDR_W-1:0] = rev_end;
		end else if (paddr == `CPR_OFF_LOAD_PTR) begin
			rd_val[ADDR_W-1:0] = load_ptr;
		end else if (paddr == `CPR_OFF_STATUS) begin
			rd_val[`CPR_ST_STANDBY] = chip_select_n;
			rd_val[`CPR_ST_IN_RESET] = in_reset;
			rd_val[`CPR_ST_PWR_READY] = pwr_ready;
			rd_val[`CPR_ST_CASCADE_N] = cascade_enable_out_n;
			rd_val[`CPR_ST_STOPPED] = stopped;
			rd_val[`CPR_ST_ADDR_LSB +: ADDR_W] = addr;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped(paddr);
			if (setup && !pwrite) begin
				prdata <= rd_val;
			end else if (setup) begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `CPR_CTRL_RST;
			rev_start <= START_RST[ADDR_W-1:0];
			rev_end <= END_RST[ADDR_W-1:0];
			load_ptr <= {ADDR_W{1'b0}};
		end else if (wr) begin
			if (paddr == `CPR_OFF_CTRL) begin
				ctrl <= pwdata & 32'h0000_0007;
			end else if (paddr == `CPR_OFF_START) begin
				rev_start <= pwdata[ADDR_W-1:0];
			end else if (paddr == `CPR_OFF_END) begin
				rev_end <= pwdata[ADDR_W-1:0];
			end else if (paddr == `CPR_OFF_LOAD_PTR) begin
				load_ptr <= pwdata[ADDR_W-1:0];
			end else if (paddr == `CPR_OFF_LOAD_DATA) begin
				load_ptr <= load_ptr + {{(ADDR_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// Stored bitstream, loaded word by word through the data window.
	always @(posedge pclk) begin
		if (wr && paddr == `CPR_OFF_LOAD_DATA) begin
			mem[load_ptr] <= pwdata[DATA_W-1:0];
		end
	end
endmodule

// ### logic/cpr_defines.vh
// Constants for the configuration memory read-out controller.
`ifndef CPR_DEFINES_VH
`define CPR_DEFINES_VH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CPR_CLK_MHZ 100
`define CPR_RESET_RELEASE_MIN_US 500
`define CPR_RESET_RELEASE_MAX_US 3000
`define CPR_TRST_MIN_US 10000
`define CPR_RESET_RELEASE_CYC (`CPR_RESET_RELEASE_MIN_US * `CPR_CLK_MHZ)
`define CPR_TRST_CYC (`CPR_TRST_MIN_US * `CPR_CLK_MHZ)

// ****************************************************************
// Register offsets
// ****************************************************************
`define CPR_OFF_CTRL 8'h00
`define CPR_OFF_START 8'h04
`define CPR_OFF_END 8'h08
`define CPR_OFF_LOAD_PTR 8'h0c
`define CPR_OFF_LOAD_DATA 8'h10
`define CPR_OFF_STATUS 8'h14

// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define CPR_CTRL_REV_EN 0
`define CPR_CTRL_PARALLEL 1
`define CPR_CTRL_DECOMP 2
`define CPR_CTRL_RST 32'h0000_0000
`define CPR_START_RST 32'h0000_0000
`define CPR_END_RST 32'h0000_0000

// ****************************************************************
// Status fields
// ****************************************************************
`define CPR_ST_STANDBY 0
`define CPR_ST_IN_RESET 1
`define CPR_ST_PWR_READY 2
`define CPR_ST_CASCADE_N 3
`define CPR_ST_STOPPED 4
`define CPR_ST_ADDR_LSB 16

`endif

// ### logic/cpr_power_seq.v
// Power-on release delay and brown-out reset sequencer.
`timescale 1ns/1ps
`include "cpr_defines.vh"

module cpr_power_seq #(
	parameter integer REL_CYC = `CPR_RESET_RELEASE_CYC,
	parameter integer RST_CYC = `CPR_TRST_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire supply_ok,
	input wire below_pd,
	output reg ready
);
	localparam [1:0] ST_HOLD = 2'b01;
	localparam [1:0] ST_RUN = 2'b10;

	reg [1:0] state;
	reg [31:0] cnt;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_HOLD;
			cnt <= 32'h0000_0000;
			ready <= 1'b0;
		end else begin
			case (state)
				ST_HOLD: begin
					ready <= 1'b0;
					if (!supply_ok) begin
						cnt <= 32'h0000_0000;
					end else if (cnt == REL_CYC - 1) begin // R9
						cnt <= 32'h0000_0000;
						state <= ST_RUN;
						ready <= 1'b1;
					end else begin
						cnt <= cnt + 32'h0000_0001;
					end
				end
				ST_RUN: begin
					if (!below_pd) begin
						cnt <= 32'h0000_0000;
					end else if (cnt == RST_CYC - 1) begin // R10
						cnt <= 32'h0000_0000;
						state <= ST_HOLD;
						ready <= 1'b0;
					end else begin
						cnt <= cnt + 32'h0000_0001;
					end
				end
				default: begin
					state <= ST_HOLD;
					cnt <= 32'h0000_0000;
					ready <= 1'b0;
				end
			endcase
		end
	end
endmodule

// ### verif/cpr_readout_assertions.sv
// Concurrent checks on the read-out controller ports.
`timescale 1ns/1ps
module cpr_readout_checker #(
	parameter integer REL_CYC = 8
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire chip_select_n,
	input wire oe_reset_in,
	input wire oe_reset_oe,
	input wire config_pulse_n_in,
	input wire supply_ok,
	input wire data_oe,
	input wire forwarded_clock_oe,
	input wire cascade_enable_out_n
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_standby_off: assert property (chip_select_n |=> !data_oe && cascade_enable_out_n)
		else $error("standby outputs active");
	a_reset_hold: assert property (!chip_select_n && !oe_reset_in |=> !data_oe && !forwarded_clock_oe && cascade_enable_out_n)
		else $error("reset line outputs active");
	a_terminal_off: assert property (!cascade_enable_out_n |-> !data_oe && !forwarded_clock_oe)
		else $error("data driven at terminal");
	a_pulse_restart: assert property (!chip_select_n && oe_reset_in && !config_pulse_n_in |=> data_oe && cascade_enable_out_n)
		else $error("restart outputs off");
	a_power_release: assert property ($rose(supply_ok) |-> oe_reset_oe [*8] ##[1:4] !oe_reset_oe)
		else $error("power release timing");
	a_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	cover property (!cascade_enable_out_n);
	cover property (pslverr);
	cover property ($fell(oe_reset_oe));
endmodule
bind cpr_readout cpr_readout_checker #(.REL_CYC(REL_CYC)) cpr_readout_checker_inst (.*);

// ### verif/cpr_fpga_model.sv
// Configuring-side model: pulled-up lines and the data clock.
`timescale 1ns/1ps
module cpr_fpga_model (
	input wire pclk,
	input wire run,
	input wire cfg_low,
	input wire oe_reset_oe,
	input wire config_pulse_n_oe,
	input wire config_pulse_n_out,
	output wire oe_reset_in,
	output wire config_pulse_n_in,
	output logic data_clock
);
	// Both lines carry pull-ups, so a released line reads high.
	assign oe_reset_in = oe_reset_oe ? 1'b0 : 1'b1;
	assign config_pulse_n_in = cfg_low ? 1'b0 : (config_pulse_n_oe ? config_pulse_n_out : 1'b1);
	initial data_clock = 1'b0;
	// The clock stays low outside reads and until the reset line is released.
	always @(posedge pclk) begin
		data_clock <= (run && oe_reset_in) ? ~data_clock : 1'b0;
	end
endmodule

// ### verif/cpr_readout_test.sv
// Self-checking bench for the read-out controller.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
	$display("mismatch at %0t got %h exp %h", $time, a, b); end end
module cpr_readout_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cs_n = 1, busy = 0;
	logic run = 0, cfg_low = 0, supply_ok = 0, below = 0, err;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	int num_errors = 0, checks = 0, cyc = 0;
	wire [31:0] prdata;
	wire [7:0] data_out;
	wire pready, pslverr, ori, oro, cfi, cfo, cfe, dclk, data_oe, fco, cas_n, rso, fcl;
	cpr_readout #(.ADDR_W(4), .DATA_W(8), .REL_CYC(8), .RST_CYC(16)) cpr_readout_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chip_select_n(cs_n), .oe_reset_in(ori), .oe_reset_out(rso), .oe_reset_oe(oro),
		.config_pulse_n_in(cfi), .config_pulse_n_out(cfo), .config_pulse_n_oe(cfe),
		.busy(busy), .data_clock(dclk), .supply_ok(supply_ok), .core_below_pd(below),
		.data_out(data_out), .data_oe(data_oe), .forwarded_clock_out(fcl),
		.forwarded_clock_oe(fco), .cascade_enable_out_n(cas_n));
	cpr_fpga_model cpr_fpga_model_inst (.pclk(pclk), .run(run), .cfg_low(cfg_low),
		.oe_reset_oe(oro), .config_pulse_n_oe(cfe), .config_pulse_n_out(cfo),
		.oe_reset_in(ori), .config_pulse_n_in(cfi), .data_clock(dclk));
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			finish_test;
		end
	end
	task finish_test;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	function automatic logic [7:0] ev(input int i);
		return 8'hc3 ^ i[7:0];
	endfunction
	task step(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Each read is one rising edge of the data clock.
	task reads(input int n);
		@(posedge pclk);
		run <= 1;
		repeat (2 * n) @(posedge pclk);
		run <= 0;
		step(3);
	endtask
	task pulse;
		@(posedge pclk);
		cfg_low <= 1;
		step(2);
		cfg_low <= 0;
		step(2);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_power;
		@(posedge pclk);
		supply_ok <= 1;
		step(6);
		`CHK(oro, 1'b1)
		`CHK({rso, cfo, cfe}, 3'b010)
		step(6);
		`CHK(oro, 1'b0)
		$display("power-up done");
	endtask
	task t_regs;
		apb(1, 8'h04, 32'h4);
		apb(0, 8'h04, 0);
		`CHK(rd, 32'h4)
		apb(0, 8'h20, 0);
		`CHK({err, rd}, 33'h1_0000_0000)
		apb(1, 8'h0c, 0);
		for (int i = 0; i < 16; i++) apb(1, 8'h10, ev(i));
		$display("registers done");
	endtask
	task t_stream;
		cs_n <= 0;
		pulse;
		reads(3);
		`CHK(data_out, ev(3))
		reads(12);
		`CHK({data_oe, cas_n}, 2'b00)
		reads(2);
		apb(0, 8'h14, 0);
		`CHK(rd[19:16], 4'hf)
		$display("stream done");
	endtask
	task t_rev;
		apb(1, 8'h08, 32'h7);
		apb(1, 8'h00, 32'h1);
		pulse;
		apb(0, 8'h14, 0);
		`CHK(rd[19:16], 4'h4)
		reads(3);
		`CHK({data_oe, fco, cas_n}, 3'b001)
		$display("revision done");
	endtask
	task t_busy;
		apb(1, 8'h00, 32'h2);
		pulse;
		reads(1);
		busy <= 1;
		reads(2);
		`CHK(data_out, ev(1))
		`CHK({fcl, data_oe, fco}, 3'b011)
		apb(1, 8'h00, 32'h6);
		reads(2);
		`CHK(data_out, ev(3))
		busy <= 0;
		$display("busy done");
	endtask
	task t_standby;
		cs_n <= 1;
		step(2);
		`CHK({data_oe, fco, cas_n}, 3'b001)
		apb(0, 8'h14, 0);
		`CHK(rd[19:16], 4'h0)
		cs_n <= 0;
		$display("standby done");
	endtask
	task t_brown;
		below <= 1;
		step(20);
		`CHK(oro, 1'b1)
		below <= 0;
		step(20);
		`CHK(oro, 1'b0)
		$display("brown-out done");
	endtask
	initial begin
		step(3);
		presetn <= 1;
		t_power;
		t_regs;
		t_stream;
		t_rev;
		t_busy;
		t_standby;
		t_brown;
		finish_test;
	end
endmodule
